// ==== rtl/pwr_down_ctrl.sv ====
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// R1: mode comes from bits 15..10 of control word
// R2: software writes the whole field at once
// R3: software writes zero to the top field bit
// R4: selected mode takes effect nine cycles after write
// R5: software pads nops after the write
// R6: non-enabled wake resumes at the sleep point
// R7: enabled wake runs the service routine first
// R8: service routine needs both global and nmi enables
// R9: clock and oscillator stop end only on reset
// R10: zero is run; 001001 light sleep, enabled wake
// R11: 010001 blocks cpu clocks, any interrupt wakes
// R12: dma keeps running during light sleep
// R13: 011010 halts pll output, whole chip stops
// R14: 011100 halts pll input, relock after reset
// R15: oscillator stop wakes slower than clock stop
// R16: clock stop modes retain registers and memory
// R17: clock stop modes freeze functional outputs
// R18: attached emulator masks sleep until reset or detach
// R19: deep sleep spins emulator runs, fails pc writes
// R20: reserved encodings act as no power-down
module pwr_down_ctrl
  import pwr_down_pkg::*;
#(
  parameter int N_IRQ = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic [N_IRQ-1:0] irq_pending,
  input  wire logic [31:0]      cpu_pc,
  input  wire logic             pll_locked_pin,
  input  wire logic             emu_attached_pin,
  input  wire logic             emu_reset_pin,
  input  wire logic             emu_exec_req,
  input  wire logic             emu_pc_wr,
  output logic                  cpu_halt,
  output logic                  cpu_clk_block,
  output logic                  pll_out_stop,
  output logic                  pll_in_stop,
  output logic                  io_freeze,
  output logic                  dma_allow,
  output logic                  core_ready,
  output logic                  wake_pulse,
  output logic                  isr_take,
  output logic [31:0]           resume_pc,
  output logic                  emu_spin,
  output logic                  emu_pc_wr_fail
);


  // pin inputs from outside the core clock domain

  logic pll_locked;
  logic emu_attached;
  logic emu_reset_lvl;
  logic emu_reset_prev_r;
  logic emu_reset_evt;

  pin_sync u_sync_lock (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (pll_locked_pin),
    .level   (pll_locked)
  );

  pin_sync u_sync_emu_att (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (emu_attached_pin),
    .level   (emu_attached)
  );

  pin_sync u_sync_emu_rst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (emu_reset_pin),
    .level   (emu_reset_lvl)
  );

  assign emu_reset_evt = emu_reset_lvl && !emu_reset_prev_r;


  // bus slave: zero wait state, always OKAY

  logic [OFF_W-1:0] addr_r;
  logic             wr_pend_r;
  logic [31:0]      hrdata_r;
  logic             bus_take;
  logic             bus_wr_take;
  logic             bus_rd_take;
  logic             csw_wr;
  logic             iem_wr;
  logic [31:0]      rd_word;
  logic [OFF_W-1:0] rd_off;

  assign hreadyout   = 1'b1;
  assign hresp       = HRESP_OKAY;
  assign hrdata      = hrdata_r;
  assign bus_take    = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign bus_wr_take = bus_take && hwrite;
  assign bus_rd_take = bus_take && !hwrite;
  assign csw_wr      = wr_pend_r && (addr_r == OFF_CSW);
  assign iem_wr      = wr_pend_r && (addr_r == OFF_IEM);
  assign rd_off      = haddr[OFF_W-1:0];


  // software-visible state

  logic [PDS_W-1:0] pds_r;
  logic [PDS_W-1:0] pds_nxt;
  logic             gie_r;
  logic [N_IRQ-1:0] iem_r;
  logic             nmi_gate_enable;
  logic [31:0]      csw_word;
  logic [31:0]      iem_word;
  logic [31:0]      stat_word;
  pd_mode_t         sel_mode;

  assign sel_mode = decode_mode(pds_r);  // [R1] [R20]
  assign nmi_gate_enable     = iem_r[NMI_GATE_ENABLE_BIT];


  // emulator masking

  logic emu_mask_r;
  logic emu_att_prev_r;
  logic emu_att_evt;
  logic emu_mask_nxt;

  assign emu_att_evt  = emu_attached && !emu_att_prev_r;
  // masking holds from attach until emulator reset or cable removal
  assign emu_mask_nxt = emu_att_evt ? 1'b1 :
                        ((emu_reset_evt || !emu_attached) ? 1'b0 : emu_mask_r);  // [R18]


  // timers

  logic entry_load;
  logic entry_abort;
  logic entry_busy;
  logic entry_done;
  logic settle_load;
  logic settle_abort;
  logic settle_done;

  cycle_timer #(
    .W (TMR_W)
  ) u_entry_tmr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (entry_load),
    .load_val (ENTRY_LOAD),
    .abort    (entry_abort),
    .busy     (entry_busy),
    .done     (entry_done)
  );

  cycle_timer #(
    .W (TMR_W)
  ) u_settle_tmr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (settle_load),
    .load_val (SETTLE_LOAD),
    .abort    (settle_abort),
    .busy     (),
    .done     (settle_done)
  );


  // sequencer

  pd_state_t        state_r;
  pd_state_t        state_nxt;
  logic [N_IRQ-1:0] irq_enabled;
  logic             hit_enabled;
  logic             hit_any;
  logic             wake_light;
  logic             wake_isr;
  logic             enter_now;
  logic             deep;
  logic             light;
  logic             req_mode_sleep;

  assign irq_enabled    = irq_pending & iem_r;
  assign hit_enabled    = |irq_enabled;
  assign hit_any        = |irq_pending;
  assign req_mode_sleep = (decode_mode(pds_nxt) != MODE_NONE);
  assign deep           = (state_r == ST_CLK_STOP) || (state_r == ST_OSC_STOP);
  assign light          = (state_r == ST_LIGHT_EN) || (state_r == ST_LIGHT_ANY);
  assign enter_now      = (state_r == ST_PEND) && entry_done && !emu_mask_r;  // [R4] [R18]

  // light sleep ends on an enabled hit, on any hit in the clock-blocked variant, or when emulator masking is set
  assign wake_light = ((state_r == ST_LIGHT_EN) && hit_enabled) ||  // [R10]
                      ((state_r == ST_LIGHT_ANY) && hit_any) ||     // [R11]
                      (light && emu_mask_r);                        // [R18]
  // the service routine runs only for an enabled hit with both gates open
  assign wake_isr   = wake_light && hit_enabled && gie_r && nmi_gate_enable;  // [R7] [R8]

  // a write of a sleep encoding to the whole field restarts the entry countdown
  assign entry_load  = csw_wr && req_mode_sleep && !deep && (state_r != ST_LOCK)
                       && (state_r != ST_SETTLE);  // [R2] [R4]
  assign entry_abort = csw_wr && !req_mode_sleep;  // [R20]

  // settle count starts once the pll reports lock after reset
  assign settle_load  = (state_r == ST_LOCK) && pll_locked;  // [R14] [R15]
  assign settle_abort = (state_r == ST_SETTLE) && !pll_locked;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_LOCK: begin
        if (pll_locked) state_nxt = ST_SETTLE;  // [R14]
      end
      ST_SETTLE: begin
        if (!pll_locked) state_nxt = ST_LOCK;
        else if (settle_done) state_nxt = ST_RUN;  // [R15]
      end
      ST_RUN: begin
        if (entry_load) state_nxt = ST_PEND;
      end
      ST_PEND: begin
        if (entry_abort) state_nxt = ST_RUN;
        else if (entry_done && emu_mask_r) state_nxt = ST_RUN;  // [R18]
        else if (enter_now) begin
          unique case (sel_mode)
            MODE_LIGHT_EN:  state_nxt = ST_LIGHT_EN;   // [R10]
            MODE_LIGHT_ANY: state_nxt = ST_LIGHT_ANY;  // [R11]
            MODE_CLK_STOP:  state_nxt = ST_CLK_STOP;   // [R13]
            MODE_OSC_STOP:  state_nxt = ST_OSC_STOP;   // [R14]
            default:        state_nxt = ST_RUN;        // [R20]
          endcase
        end
      end
      ST_LIGHT_EN, ST_LIGHT_ANY: begin
        if (wake_light) state_nxt = ST_RUN;  // [R6]
      end
      ST_CLK_STOP, ST_OSC_STOP: begin
        state_nxt = state_r;  // [R9]
      end
      default: state_nxt = ST_LOCK;
    endcase
  end

  // field is cleared by hardware on a light-sleep wake; a software write in
  // the same cycle wins so the new request is not lost
  always_comb begin
    pds_nxt = pds_r;
    if (wake_light) pds_nxt = PDS_NONE;
    if (csw_wr) pds_nxt = hwdata[PDS_MSB:PDS_LSB];  // [R1] [R3]
  end


  // read data

  assign csw_word  = {16'h0000, pds_r, 9'h000, gie_r};
  assign iem_word  = 32'(iem_r);
  assign stat_word = {25'h000_0000, pll_locked, core_ready, emu_mask_r, 1'b0, state_r};
  assign rd_word   = (rd_off == OFF_CSW)  ? csw_word  :
                     (rd_off == OFF_IEM)  ? iem_word  :
                     (rd_off == OFF_STAT) ? stat_word : WORD_ZERO;


  // registers

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_r    <= OFF_CSW;
      wr_pend_r <= 1'b0;
      hrdata_r  <= WORD_ZERO;
    end else begin
      wr_pend_r <= bus_wr_take;
      addr_r    <= bus_take ? rd_off : addr_r;
      hrdata_r  <= bus_rd_take ? rd_word : hrdata_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pds_r <= PDS_NONE;
      gie_r <= 1'b0;
      iem_r <= '0;
    end else begin
      pds_r <= pds_nxt;
      gie_r <= csw_wr ? hwdata[GIE_BIT] : gie_r;
      iem_r <= iem_wr ? hwdata[N_IRQ-1:0] : iem_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      emu_mask_r       <= 1'b0;
      emu_att_prev_r   <= 1'b0;
      emu_reset_prev_r <= 1'b0;
    end else begin
      emu_mask_r       <= emu_mask_nxt;
      emu_att_prev_r   <= emu_attached;
      emu_reset_prev_r <= emu_reset_lvl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_LOCK;
    end else begin
      state_r <= state_nxt;
    end
  end


  // gating outputs, registered from the next state so they do not glitch

  logic cpu_halt_r;
  logic cpu_clk_block_r;
  logic pll_out_stop_r;
  logic pll_in_stop_r;
  logic io_freeze_r;
  logic dma_allow_r;
  logic core_ready_r;
  logic wake_pulse_r;
  logic isr_take_r;
  logic [31:0] resume_pc_r;
  logic n_deep;
  logic n_light;

  assign n_deep  = (state_nxt == ST_CLK_STOP) || (state_nxt == ST_OSC_STOP);
  assign n_light = (state_nxt == ST_LIGHT_EN) || (state_nxt == ST_LIGHT_ANY);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_halt_r      <= 1'b1;
      cpu_clk_block_r <= 1'b0;
      pll_out_stop_r  <= 1'b0;
      pll_in_stop_r   <= 1'b0;
      io_freeze_r     <= 1'b0;
      dma_allow_r     <= 1'b0;
      core_ready_r    <= 1'b0;
    end else begin
      cpu_halt_r      <= n_light || n_deep || (state_nxt == ST_LOCK) || (state_nxt == ST_SETTLE);
      cpu_clk_block_r <= (state_nxt == ST_LIGHT_ANY);  // [R11]
      pll_out_stop_r  <= (state_nxt == ST_CLK_STOP);   // [R13]
      pll_in_stop_r   <= (state_nxt == ST_OSC_STOP);   // [R14]
      io_freeze_r     <= n_deep;                       // [R17] [R16]
      dma_allow_r     <= !n_deep && (state_nxt != ST_LOCK) && (state_nxt != ST_SETTLE);  // [R12]
      core_ready_r    <= (state_nxt != ST_LOCK) && (state_nxt != ST_SETTLE);  // [R15]
    end
  end

  // resume point is captured when sleep takes effect and kept until the next entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_pulse_r <= 1'b0;
      isr_take_r   <= 1'b0;
      resume_pc_r  <= WORD_ZERO;
    end else begin
      wake_pulse_r <= wake_light;             // [R6]
      isr_take_r   <= wake_isr;               // [R7] [R8]
      resume_pc_r  <= enter_now ? cpu_pc : resume_pc_r;  // [R6] [R16]
    end
  end

  assign cpu_halt       = cpu_halt_r;
  assign cpu_clk_block  = cpu_clk_block_r;
  assign pll_out_stop   = pll_out_stop_r;
  assign pll_in_stop    = pll_in_stop_r;
  assign io_freeze      = io_freeze_r;
  assign dma_allow      = dma_allow_r;
  assign core_ready     = core_ready_r;
  assign wake_pulse     = wake_pulse_r;
  assign isr_take       = isr_take_r;
  assign resume_pc      = resume_pc_r;

  // emulator requests are answered combinationally while deep sleep holds
  assign emu_spin       = deep && emu_exec_req;  // [R19]
  assign emu_pc_wr_fail = deep && emu_pc_wr;     // [R19]

endmodule

// ==== inc/pwr_down_pkg.sv ====
package pwr_down_pkg;

  // core clock
  localparam int          CLK_PERIOD_NS   = 100;

  // countdown widths and timing
  localparam int          TMR_W           = 8;
  localparam int          ENTRY_DELAY_CYC = 9;
  localparam int          SETTLE_NS       = 1000;
  localparam int          SETTLE_CYC_RAW  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC      = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam logic [TMR_W-1:0] ENTRY_LOAD  = TMR_W'(ENTRY_DELAY_CYC);
  localparam logic [TMR_W-1:0] SETTLE_LOAD = TMR_W'(SETTLE_CYC);

  // register offsets (byte addresses)
  localparam int          OFF_W           = 8;
  localparam logic [OFF_W-1:0] OFF_CSW     = 8'h00;
  localparam logic [OFF_W-1:0] OFF_IEM     = 8'h04;
  localparam logic [OFF_W-1:0] OFF_STAT    = 8'h08;

  // control_status_word layout
  localparam int          PDS_MSB         = 15;
  localparam int          PDS_LSB         = 10;
  localparam int          PDS_W           = PDS_MSB - PDS_LSB + 1;
  localparam int          GIE_BIT         = 0;
  // irq_enable_mask layout
  localparam int          NMI_GATE_ENABLE_BIT        = 1;
  // status layout
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_EMU_MASK_BIT = 4;
  localparam int          ST_READY_BIT    = 5;
  localparam int          ST_LOCKED_BIT   = 6;

  // power_down_select encodings
  localparam logic [PDS_W-1:0] PDS_NONE      = 6'h00;
  localparam logic [PDS_W-1:0] PDS_LIGHT_EN  = 6'h09;
  localparam logic [PDS_W-1:0] PDS_LIGHT_ANY = 6'h11;
  localparam logic [PDS_W-1:0] PDS_CLK_STOP  = 6'h1A;
  localparam logic [PDS_W-1:0] PDS_OSC_STOP  = 6'h1C;

  // bus constants
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'h0;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_LIGHT_EN, MODE_LIGHT_ANY, MODE_CLK_STOP, MODE_OSC_STOP
  } pd_mode_t;

  typedef enum logic [2:0] {
    ST_LOCK, ST_SETTLE, ST_RUN, ST_PEND, ST_LIGHT_EN, ST_LIGHT_ANY, ST_CLK_STOP, ST_OSC_STOP
  } pd_state_t;

  // reserved encodings behave as no power-down
  function automatic pd_mode_t decode_mode(input logic [PDS_W-1:0] pds);
    pd_mode_t m;
    m = MODE_NONE;
    if (pds == PDS_LIGHT_EN) m = MODE_LIGHT_EN;
    if (pds == PDS_LIGHT_ANY) m = MODE_LIGHT_ANY;
    if (pds == PDS_CLK_STOP) m = MODE_CLK_STOP;
    if (pds == PDS_OSC_STOP) m = MODE_OSC_STOP;
    return m;
  endfunction

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // a change is accepted once the second and third stage agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= (s2_r == s3_r) ? s3_r : level_r;
    end
  end

  assign level = level_r;
endmodule

// ==== rtl/cycle_timer.sv ====
`timescale 1ns/10ps
module cycle_timer #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         abort,
  output logic              busy,
  output logic              done
);
  localparam logic [W-1:0] ONE  = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // done marks the edge on which the count reaches zero
  assign busy    = (cnt_r != ZERO);
  assign done    = (cnt_r == ONE) && !abort && !load;
  assign cnt_nxt = abort ? ZERO : (load ? load_val : (busy ? cnt_r - ONE : ZERO));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== dv/pwr_down_ctrl_properties.sv ====
`timescale 1ns/10ps
module pwr_down_ctrl_properties
  import pwr_down_pkg::*;
#(
  parameter int N_IRQ = 16
) (
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic             emu_attached_pin,
  input wire logic             emu_exec_req,
  input wire logic             emu_pc_wr,
  input wire logic             cpu_halt,
  input wire logic             cpu_clk_block,
  input wire logic             pll_out_stop,
  input wire logic             pll_in_stop,
  input wire logic             io_freeze,
  input wire logic             dma_allow,
  input wire logic             core_ready,
  input wire logic             wake_pulse,
  input wire logic             isr_take,
  input wire logic [31:0]      resume_pc,
  input wire logic             emu_spin,
  input wire logic             emu_pc_wr_fail
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [PDS_W-1:0] field;
  logic             sleep_code;
  assign field      = hwdata[PDS_MSB:PDS_LSB];
  assign sleep_code = field inside {PDS_LIGHT_EN, PDS_LIGHT_ANY, PDS_CLK_STOP, PDS_OSC_STOP};

  // accepted control word write from a running, unmasked core
  sequence s_csw_wr;
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == OFF_CSW
    ##1 core_ready && !cpu_halt && !emu_attached_pin;
  endsequence
  sequence s_wake;
    !cpu_halt && $past(cpu_halt) ##1 !wake_pulse;
  endsequence

  property p_bus_ok; hreadyout && hresp == HRESP_OKAY; endproperty
  property p_enter_halt; s_csw_wr ##0 sleep_code |-> ##9 !cpu_halt ##1 cpu_halt; endproperty
  property p_enter_clk; s_csw_wr ##0 field == PDS_CLK_STOP |-> ##10 pll_out_stop && io_freeze && !pll_in_stop; endproperty
  property p_enter_osc; s_csw_wr ##0 field == PDS_OSC_STOP |-> ##10 pll_in_stop && io_freeze && !pll_out_stop; endproperty
  property p_reserved; s_csw_wr ##0 !sleep_code |=> !cpu_halt [*8] ##1 !cpu_halt ##1 !cpu_halt; endproperty
  property p_wake_any; cpu_clk_block && (|irq_pending) |=> !cpu_halt && wake_pulse; endproperty
  property p_wake_pulse; wake_pulse |-> s_wake; endproperty
  property p_isr; isr_take |-> wake_pulse; endproperty
  property p_deep_hold; io_freeze |=> io_freeze && cpu_halt && $stable(resume_pc) && !wake_pulse; endproperty
  property p_freeze; io_freeze == (pll_out_stop || pll_in_stop) && !(pll_out_stop && pll_in_stop); endproperty
  property p_spin; emu_spin == (io_freeze && emu_exec_req) && emu_pc_wr_fail == (io_freeze && emu_pc_wr); endproperty
  property p_light_dma; cpu_halt && !io_freeze && core_ready |-> dma_allow; endproperty
  property p_clk_block; cpu_clk_block |-> cpu_halt && !io_freeze; endproperty

  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");
  a_enter_halt: assert property (p_enter_halt) else $error("sleep not entered nine cycles after write");
  a_enter_clk: assert property (p_enter_clk) else $error("clock stop outputs wrong");
  a_enter_osc: assert property (p_enter_osc) else $error("oscillator stop outputs wrong");
  a_reserved: assert property (p_reserved) else $error("reserved field entered sleep");
  a_wake_any: assert property (p_wake_any) else $error("blocked light sleep missed interrupt");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse without wake");
  a_isr: assert property (p_isr) else $error("service request without wake");
  a_deep_hold: assert property (p_deep_hold) else $error("deep sleep left without reset");
  a_freeze: assert property (p_freeze) else $error("freeze does not match deep mode");
  a_spin: assert property (p_spin) else $error("emulator spin or pc fail wrong");
  a_light_dma: assert property (p_light_dma) else $error("dma stopped in light sleep");
  a_clk_block: assert property (p_clk_block) else $error("clock block outside light sleep");
endmodule

bind pwr_down_ctrl pwr_down_ctrl_properties #(.N_IRQ(N_IRQ)) i_pwr_down_ctrl_properties (.*);

// ==== dv/cpu_pll_model.sv ====
`timescale 1ns/10ps
module cpu_pll_model #(
  parameter int LOCK_CYC = 40
) (
  input  wire logic  ref_clk,
  input  wire logic  cpu_halt,
  input  wire logic  pll_in_stop,
  output logic [31:0] cpu_pc,
  output logic        pll_locked_pin
);
  int lock_cnt;
  initial begin
    cpu_pc = 32'h0000_0100;
    pll_locked_pin = 1'h0;
    lock_cnt = 0;
  end
  // the pll is not reset with the device, so relock runs across the reset
  always @(posedge ref_clk) begin
    if (!cpu_halt)
      cpu_pc <= cpu_pc + 32'h1;
    if (pll_in_stop) begin
      pll_locked_pin <= 1'h0;
      lock_cnt <= 0;
    end else if (lock_cnt < LOCK_CYC)
      lock_cnt <= lock_cnt + 1;
    else
      pll_locked_pin <= 1'h1;
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp=%h got=%h", nm, e, g); end end
module tb_top;
  import pwr_down_pkg::*;
  typedef struct packed { logic isr; logic [31:0] pc; } wake_exp_t;
  logic        ref_clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        emu_attached_pin = 1'h0, emu_reset_pin = 1'h0, emu_exec_req = 1'h0, emu_pc_wr = 1'h0;
  logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, rd, rs = 32'h0000_6992, tmp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] irq_pending = 16'h0000, nonen;
  logic [5:0]  code;
  logic [31:0] hrdata, cpu_pc, resume_pc;
  logic        hreadyout, hresp, pll_locked_pin, cpu_halt, cpu_clk_block, pll_out_stop, pll_in_stop;
  logic        io_freeze, dma_allow, core_ready, wake_pulse, isr_take, emu_spin, emu_pc_wr_fail;
  int          num_errors = 0, n_compared = 0, i, t, t_wake [2];
  wake_exp_t   exp_q [$];
  wake_exp_t   we;
  logic [5:0]  w_code [5] = '{PDS_LIGHT_EN, PDS_LIGHT_EN, PDS_LIGHT_EN, PDS_LIGHT_ANY, PDS_LIGHT_ANY};
  logic [15:0] w_iem [5] = '{16'h0006, 16'h0004, 16'h0006, 16'h0006, 16'h0006};
  logic [15:0] w_irq [5] = '{16'h0004, 16'h0004, 16'h0004, 16'h0000, 16'h0004};
  logic        w_gie [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
  logic        w_isr [5] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1};

  initial forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  pwr_down_ctrl i_pwr_down_ctrl (.*, .hready(hreadyout));
  cpu_pll_model i_cpu_pll_model (.*);

  function automatic logic [31:0] xorshift();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timed_out(input string what);
    num_errors++;
    $display("mismatch %s exp=done got=timeout", what);
    report_and_stop();
  endtask

  // one single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'h1 && n < 20);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'h1 && n < 40);
    rd = hrdata;
    if (n >= 40)
      timed_out("bus");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'h0, a, WORD_ZERO);
    `CHK(nm, e, rd)
  endtask

  task automatic wait_for(input int s, input logic v);
    int n;
    n = 0;
    while ((s == 0 ? cpu_halt : s == 1 ? io_freeze : core_ready) !== v && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300)
      timed_out("wait");
  endtask

  task automatic do_reset(output int tr);
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    tr = 0;
    while (core_ready !== 1'h1 && tr < 300) begin
      @(negedge ref_clk);
      tr++;
    end
    if (tr >= 300)
      timed_out("ready");
  endtask

  always @(negedge ref_clk) begin
    if (wake_pulse === 1'h1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch wake exp=none got=pulse");
      end else begin
        we = exp_q.pop_front();
        `CHK("isr_take", we.isr, isr_take)
        `CHK("resume_pc", we.pc, resume_pc)
      end
    end
  end

  initial begin
    do_reset(t);
    rd_chk(OFF_CSW, WORD_ZERO, "csw_reset");
    rd_chk(OFF_STAT, 32'h0000_0062, "stat_run");
    xfer(1'h1, OFF_CSW, 32'hFFFF_FFFF);
    repeat (12) @(negedge ref_clk);
    `CHK("halt_reserved", 1'h0, cpu_halt)
    rd_chk(OFF_CSW, 32'h0000_FC01, "csw_fields");
    xfer(1'h1, OFF_STAT, 32'hFFFF_FFFF);
    rd_chk(OFF_STAT, 32'h0000_0062, "stat_ro");
    rd_chk(8'h0C, WORD_ZERO, "unmapped");
    for (i = 0; i < 4; i++) begin
      tmp = xorshift();
      code = tmp[5:0] | 6'h20;
      xfer(1'h1, OFF_CSW, {16'h0000, code, 10'h000});
      repeat (12) @(negedge ref_clk);
      `CHK("halt_reserved", 1'h0, cpu_halt)
    end
    for (i = 0; i < 5; i++) begin
      tmp = xorshift();
      nonen = 16'h0100 << tmp[2:0];
      xfer(1'h1, OFF_IEM, {16'h0000, w_iem[i]});
      xfer(1'h1, OFF_CSW, {16'h0000, w_code[i], 9'h000, w_gie[i]});
      wait_for(0, 1'h1);
      `CHK("clk_block", w_code[i] == PDS_LIGHT_ANY, cpu_clk_block)
      `CHK("dma_allow", 1'h1, dma_allow)
      rd_chk(OFF_STAT, (w_code[i] == PDS_LIGHT_EN) ? 32'h0000_0064 : 32'h0000_0065, "stat_light");
      exp_q.push_back('{w_isr[i], cpu_pc - 32'h1});
      if (w_code[i] == PDS_LIGHT_EN) begin
        @(posedge ref_clk);
        irq_pending <= nonen;
        repeat (6) @(negedge ref_clk);
        `CHK("halt_nonen", 1'h1, cpu_halt)
      end
      @(posedge ref_clk);
      irq_pending <= (w_irq[i] == 16'h0000) ? nonen : w_irq[i];
      wait_for(0, 1'h0);
      @(posedge ref_clk);
      irq_pending <= 16'h0000;
      repeat (4) @(negedge ref_clk);
    end
    `CHK("wakes_left", 0, exp_q.size())
    @(posedge ref_clk);
    emu_attached_pin <= 1'h1;
    repeat (8) @(negedge ref_clk);
    xfer(1'h1, OFF_CSW, {16'h0000, PDS_LIGHT_EN, 10'h000});
    repeat (12) @(negedge ref_clk);
    `CHK("halt_emu", 1'h0, cpu_halt)
    rd_chk(OFF_STAT, 32'h0000_0072, "stat_emu");
    @(posedge ref_clk);
    emu_reset_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    emu_reset_pin <= 1'h0;
    repeat (6) @(negedge ref_clk);
    rd_chk(OFF_STAT, 32'h0000_0062, "stat_emu_rst");
    @(posedge ref_clk);
    emu_attached_pin <= 1'h0;
    repeat (8) @(negedge ref_clk);
    for (i = 0; i < 2; i++) begin
      code = (i == 1) ? PDS_OSC_STOP : PDS_CLK_STOP;
      @(posedge ref_clk);
      emu_exec_req <= 1'h1;
      emu_pc_wr <= 1'h1;
      xfer(1'h1, OFF_CSW, {16'h0000, code, 9'h000, 1'h1});
      wait_for(1, 1'h1);
      @(posedge ref_clk);
      irq_pending <= 16'hFFFF;
      repeat (6) @(negedge ref_clk);
      `CHK("halt_deep", 1'h1, cpu_halt)
      `CHK("pll_out_stop", i == 0, pll_out_stop)
      `CHK("pll_in_stop", i == 1, pll_in_stop)
      `CHK("emu_spin", 1'h1, emu_spin)
      `CHK("emu_pc_wr_fail", 1'h1, emu_pc_wr_fail)
      rd_chk(OFF_CSW, {16'h0000, code, 9'h000, 1'h1}, "csw_deep");
      @(posedge ref_clk);
      irq_pending <= 16'h0000;
      emu_exec_req <= 1'h0;
      emu_pc_wr <= 1'h0;
      do_reset(t);
      t_wake[i] = t;
    end
    `CHK("osc_slower", 1'h1, t_wake[1] > t_wake[0])
    report_and_stop();
  end
endmodule
